// ---- rtl/sbc_control_status_regs.v ----
// Purpose: Control and status register bank behind the 16-bit serial port
// Assumes: Serial pins and analog comparator levels are asynchronous to clk
// Notes:   Host drives data on falling and samples on rising serial clock
`include "sbc_regs_map.vh"

module sbc_control_status_regs #(
  parameter RSTOUT_CYC = `RSTOUT_CYC
) (
  // System
  input  wire        clk,
  input  wire        rst_b,
  // Serial pins
  input  wire        spi_sck,
  input  wire        spi_cs_n,
  input  wire        spi_mosi,
  output reg         spi_miso_q,
  output reg         spi_miso_oe_n_q,
  // Device state and events, clk domain
  input  wire        normal_mode,
  input  wire        soft_reset,
  input  wire        restart,
  input  wire        failsafe_entry,
  input  wire        hw_ch3_mode_wr,
  input  wire [1:0]  hw_ch3_mode,
  input  wire [7:0]  status_event,
  // Analog and strap levels, asynchronous
  input  wire        supply_config_pin,
  input  wire        battery_sense_low,
  // Control outputs
  output reg         adc_battery_sel_q,
  output reg         boost_lowbatt_cutoff_q,
  output reg         boost_off_q,
  output reg  [1:0]  boost_level_q,
  output reg  [1:0]  aux_supply_level_sel_q,
  output reg         ch0_fast_q,
  output reg         ch3_fast_q,
  output reg  [1:0]  ch3_mode_q,
  output reg  [2:0]  wake_period_sel_q,
  output reg  [10:0] wake_interval_ms_q,
  output reg         reset_out_n_q
);

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  reg         sck_prev_q;
  reg         cs_prev_q;

  wire        sck_s      = sync2_q[0];
  wire        cs_n_s     = sync2_q[1];
  wire        mosi_s     = sync2_q[2];
  wire        cfg_high_s = sync2_q[3];
  wire        lowbatt_s  = sync2_q[4];
  wire        sck_rise   = sck_s & ~sck_prev_q & ~cs_n_s;
  wire        sck_fall   = ~sck_s & sck_prev_q & ~cs_n_s;
  wire        cs_fall    = ~cs_n_s & cs_prev_q;
  wire        cs_rise    = cs_n_s & ~cs_prev_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q    <= 5'h1a;
      sync2_q    <= 5'h1a;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end
    else
    begin
      sync1_q    <= {battery_sense_low, supply_config_pin, spi_mosi, spi_cs_n, spi_sck};
      sync2_q    <= sync1_q;
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
    end
  end

  // --------------------------------------------------------------------
  // Frame receive and transmit
  // --------------------------------------------------------------------
  reg  [15:0] rx_q;
  reg  [7:0]  tx_lo_q;
  reg  [7:0]  tx_hi_q;
  reg  [4:0]  bit_cnt_q;
  reg  [7:0]  rd_data;
  reg  [7:0]  evstat_q;

  wire        frame_ok  = cs_rise && (bit_cnt_q == 5'd16);
  wire [6:0]  f_addr    = rx_q[`FRM_ADDR_HI:0];
  wire        f_mode    = rx_q[`FRM_MODE_BIT];
  wire [7:0]  f_data    = rx_q[`FRM_DATA_HI:`FRM_DATA_LO];
  wire [15:0] tx_frame  = {tx_hi_q, tx_lo_q};

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_q            <= 16'h0000;
      tx_lo_q         <= 8'h00;
      tx_hi_q         <= 8'h00;
      bit_cnt_q       <= 5'h00;
      spi_miso_q      <= 1'b0;
      spi_miso_oe_n_q <= 1'b1;
    end
    else if (cs_n_s)
    begin
      bit_cnt_q       <= (cs_rise) ? bit_cnt_q : 5'h00;
      spi_miso_oe_n_q <= 1'b1;
    end
    else if (cs_fall)
    begin
      bit_cnt_q       <= 5'h00;
      tx_lo_q         <= {7'h00, |evstat_q};
      tx_hi_q         <= 8'h00;
      spi_miso_q      <= |evstat_q;
      spi_miso_oe_n_q <= 1'b0;
    end
    else
    begin
      spi_miso_oe_n_q <= 1'b0;
      if (sck_rise)
      begin
        rx_q <= {spi_bit_in(mosi_s), rx_q[15:1]};
        if (bit_cnt_q != 5'd17)
          bit_cnt_q <= bit_cnt_q + 5'd1;
      end
      if (bit_cnt_q == 5'd8)
        tx_hi_q <= rd_data;
      if (sck_fall && bit_cnt_q < 5'd16)
        spi_miso_q <= tx_frame[bit_cnt_q[3:0]];
    end
  end

  function spi_bit_in;
    input b;
    begin
      spi_bit_in = b;
    end
  endfunction

  // Address is complete after eight rising edges; rx holds it in the top byte
  wire [6:0] rd_addr = rx_q[`FRM_DATA_LO+`FRM_ADDR_HI:`FRM_DATA_LO];

  // --------------------------------------------------------------------
  // Write decode, applied only on a whole 16-bit frame
  // --------------------------------------------------------------------
  wire wr_bus3    = frame_ok && f_mode && (f_addr == `BUS3_OFS);
  wire wr_timer   = frame_ok && f_mode && (f_addr == `TIMER_OFS);
  wire wr_hwctl   = frame_ok && f_mode && (f_addr == `HWCTL_OFS);
  wire wr_scratch = frame_ok && f_mode && (f_addr == `SCRATCH_OFS) && normal_mode;
  wire clr_evstat = frame_ok && f_mode && (f_addr == `EVSTAT_OFS);

  // --------------------------------------------------------------------
  // Wake timer control
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wake_period_sel_q <= `TIMER_RST;
    else if (soft_reset || restart)
      wake_period_sel_q <= `TIMER_RST;
    else if (wr_timer)
      wake_period_sel_q <= f_data[`TM_PER_HI:`TM_PER_LO];
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wake_interval_ms_q <= `WAKE_MS_0;
    else
    begin
      case (wake_period_sel_q)
        3'h0:    wake_interval_ms_q <= `WAKE_MS_0;
        3'h1:    wake_interval_ms_q <= `WAKE_MS_1;
        3'h2:    wake_interval_ms_q <= `WAKE_MS_2;
        3'h3:    wake_interval_ms_q <= `WAKE_MS_3;
        3'h4:    wake_interval_ms_q <= `WAKE_MS_4;
        3'h5:    wake_interval_ms_q <= `WAKE_MS_5;
        3'h6:    wake_interval_ms_q <= `WAKE_MS_6;
        default: wake_interval_ms_q <= `WAKE_MS_RSV;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Hardware control
  // --------------------------------------------------------------------
  reg softrst_pin_suppress_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      adc_battery_sel_q      <= 1'b0;
      softrst_pin_suppress_q <= 1'b0;
      boost_lowbatt_cutoff_q <= 1'b0;
      boost_level_q          <= `BOOST_RST;
    end
    else if (soft_reset)
    begin
      adc_battery_sel_q      <= 1'b0;
      softrst_pin_suppress_q <= 1'b0;
      boost_lowbatt_cutoff_q <= 1'b0;
      boost_level_q          <= `BOOST_RST;
    end
    else if (restart)
    begin
      adc_battery_sel_q      <= 1'b0;
      boost_lowbatt_cutoff_q <= 1'b0;
    end
    else if (wr_hwctl)
    begin
      adc_battery_sel_q      <= f_data[`HW_ADC_SEL_BIT];
      softrst_pin_suppress_q <= f_data[`HW_SUPPRESS_BIT];
      boost_lowbatt_cutoff_q <= f_data[`HW_CUTOFF_BIT];
      boost_level_q          <= f_data[`HW_BOOST_HI:`HW_BOOST_LO];
    end
  end

  // Aux level survives soft reset and restart; strap forces it
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      aux_supply_level_sel_q <= `AUX_RST;
    else if (!cfg_high_s)
      aux_supply_level_sel_q <= `AUX_RST;
    else if (wr_hwctl)
      aux_supply_level_sel_q <= f_data[`HW_AUX_HI:`HW_AUX_LO];
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      boost_off_q <= 1'b0;
    else
      boost_off_q <= boost_lowbatt_cutoff_q & lowbatt_s;
  end

  // --------------------------------------------------------------------
  // Reset output stretch
  // --------------------------------------------------------------------
  reg [15:0] rst_cnt_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_cnt_q     <= RSTOUT_CYC[15:0];
      reset_out_n_q <= 1'b0;
    end
    else if (soft_reset && !softrst_pin_suppress_q)
    begin
      rst_cnt_q     <= RSTOUT_CYC[15:0];
      reset_out_n_q <= 1'b0;
    end
    else if (rst_cnt_q != 16'h0000)
    begin
      rst_cnt_q     <= rst_cnt_q - 16'h0001;
      reset_out_n_q <= 1'b0;
    end
    else
      reset_out_n_q <= 1'b1;
  end

  // --------------------------------------------------------------------
  // Bus control, channels 0 and 3
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ch0_fast_q <= 1'b0;
      ch3_fast_q <= 1'b0;
      ch3_mode_q <= `MODE_RST;
    end
    else if (soft_reset)
    begin
      ch0_fast_q <= 1'b0;
      ch3_fast_q <= 1'b0;
      ch3_mode_q <= `MODE_RST;
    end
    else if (failsafe_entry)
      ch3_mode_q <= `MODE_WAKE;
    else if (hw_ch3_mode_wr)
      ch3_mode_q <= hw_ch3_mode;
    else if (wr_bus3)
    begin
      ch0_fast_q <= f_data[`B3_FAST0_BIT];
      ch3_fast_q <= f_data[`B3_FAST3_BIT];
      ch3_mode_q <= f_data[`B3_MODE_HI:`B3_MODE_LO];
    end
  end

  // --------------------------------------------------------------------
  // Scratch byte and event status
  // --------------------------------------------------------------------
  reg [7:0] host_scratch_byte_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      host_scratch_byte_q <= `SCRATCH_RST;
    else if (wr_scratch)
      host_scratch_byte_q <= f_data;
  end

  // New events win over a clear in the same cycle
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      evstat_q <= `EVSTAT_RST;
    else if (clr_evstat)
      evstat_q <= status_event;
    else
      evstat_q <= evstat_q | status_event;
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  always @*
  begin
    rd_data = 8'h00;
    case (rd_addr)
      `BUS3_OFS:
        rd_data = {3'h0, ch0_fast_q, ch3_fast_q, 1'b0, ch3_mode_q};
      `TIMER_OFS:
        rd_data = {5'h00, wake_period_sel_q};
      `HWCTL_OFS:
        rd_data = {adc_battery_sel_q, softrst_pin_suppress_q, boost_lowbatt_cutoff_q,
                   1'b0, boost_level_q, aux_supply_level_sel_q};
      `SCRATCH_OFS:
        rd_data = normal_mode ? host_scratch_byte_q : 8'h00;
      `EVSTAT_OFS:
        rd_data = evstat_q;
      default:
        rd_data = 8'h00;
    endcase
  end

endmodule // sbc_control_status_regs

// ---- rtl/sbc_regs_map.vh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock, 16-bit frames, least significant bit first
// Notes:   Definitions only
`ifndef SBC_REGS_MAP_VH
`define SBC_REGS_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (7-bit frame address)
// ----------------------------------------------------------------------
`define BUS3_OFS          7'h0b
`define TIMER_OFS         7'h0c
`define HWCTL_OFS         7'h0e
`define SCRATCH_OFS       7'h1e
`define EVSTAT_OFS        7'h40

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define FRM_BITS          16
`define FRM_ADDR_HI       6
`define FRM_MODE_BIT      7
`define FRM_DATA_LO       8
`define FRM_DATA_HI       15

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HW_ADC_SEL_BIT    7
`define HW_SUPPRESS_BIT   6
`define HW_CUTOFF_BIT     5
`define HW_BOOST_HI       3
`define HW_BOOST_LO       2
`define HW_AUX_HI         1
`define HW_AUX_LO         0
`define B3_FAST0_BIT      4
`define B3_FAST3_BIT      3
`define B3_MODE_HI        1
`define B3_MODE_LO        0
`define TM_PER_HI         2
`define TM_PER_LO         0

// ----------------------------------------------------------------------
// Reset and forced values
// ----------------------------------------------------------------------
`define TIMER_RST         3'h0
`define BOOST_RST         2'h0
`define AUX_RST           2'h1
`define MODE_RST          2'h0
`define MODE_WAKE         2'h1
`define SCRATCH_RST       8'h00
`define EVSTAT_RST        8'h00

// ----------------------------------------------------------------------
// Wake intervals in ms per period code
// ----------------------------------------------------------------------
`define WAKE_MS_0         11'd10
`define WAKE_MS_1         11'd20
`define WAKE_MS_2         11'd50
`define WAKE_MS_3         11'd100
`define WAKE_MS_4         11'd200
`define WAKE_MS_5         11'd1000
`define WAKE_MS_6         11'd2000
`define WAKE_MS_RSV       11'd0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ           25
`define RSTOUT_TIME_NS    10000
`define RSTOUT_CYC        ((`RSTOUT_TIME_NS * `CLK_MHZ) / 1000)

`endif

// ---- dv/sbc_regs_properties.sv ----
// Purpose: Port-level assertions for the control and status register bank
// Assumes: Single clk domain, rst_b asynchronous active low
// Notes:   Bound into every instance of the bank
module sbc_regs_properties #(
  parameter RSTOUT_CYC = 8
) (
  input wire        clk,
  input wire        rst_b,
  input wire        soft_reset,
  input wire        restart,
  input wire        failsafe_entry,
  input wire        hw_ch3_mode_wr,
  input wire [1:0]  hw_ch3_mode,
  input wire        supply_config_pin,
  input wire        battery_sense_low,
  input wire        adc_battery_sel_q,
  input wire        boost_lowbatt_cutoff_q,
  input wire        boost_off_q,
  input wire [1:0]  boost_level_q,
  input wire [1:0]  aux_supply_level_sel_q,
  input wire [1:0]  ch3_mode_q,
  input wire [2:0]  wake_period_sel_q,
  input wire [10:0] wake_interval_ms_q,
  input wire        reset_out_n_q
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [87:0] MS = {11'd0, 11'd2000, 11'd1000, 11'd200, 11'd100, 11'd50, 11'd20,
                                11'd10};
  logic [15:0] lo_cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Consecutive cycles with reset output held low
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      lo_cnt_q <= 16'h0;
    else
      lo_cnt_q <= reset_out_n_q ? 16'h0 : lo_cnt_q + 16'h1;

  per_decode_a: assert property (wake_interval_ms_q == MS[11*$past(wake_period_sel_q) +: 11])
    else $error("wake interval does not match period code");
  cut_on_a: assert property ((boost_lowbatt_cutoff_q && battery_sense_low) [*5] |-> boost_off_q)
    else $error("boost not switched off on low battery");
  cut_idle_a: assert property (!boost_lowbatt_cutoff_q |=> !boost_off_q)
    else $error("boost switched off with cutoff disabled");
  aux_strap_a: assert property (!supply_config_pin [*5] |-> aux_supply_level_sel_q == 2'h1)
    else $error("aux level not forced with strap grounded");
  soft_clear_a: assert property (soft_reset |=> !adc_battery_sel_q && !boost_lowbatt_cutoff_q
    && boost_level_q == 2'h0 && wake_period_sel_q == 3'h0 && $stable(aux_supply_level_sel_q))
    else $error("software reset defaults wrong");
  restart_clr_a: assert property (restart |=> wake_period_sel_q == 3'h0 && !adc_battery_sel_q
    && $stable(boost_level_q))
    else $error("restart defaults wrong");
  fail_safe_a: assert property (failsafe_entry |=> ch3_mode_q == 2'h1)
    else $error("fail-safe did not set wake capable mode");
  hw_mode_a: assert property (hw_ch3_mode_wr && !failsafe_entry && !soft_reset
    |=> ch3_mode_q == $past(hw_ch3_mode))
    else $error("hardware mode update lost");
  rst_cause_a: assert property ($fell(reset_out_n_q) |-> $past(soft_reset))
    else $error("reset output fell without software reset");
  rst_len_a: assert property ($rose(reset_out_n_q) |-> lo_cnt_q >= RSTOUT_CYC - 1)
    else $error("reset output pulse too short");

  soft_c: cover property (soft_reset ##2 !reset_out_n_q);
  fail_c: cover property (failsafe_entry);
  cut_c: cover property (boost_off_q);
endmodule // sbc_regs_properties

bind sbc_control_status_regs sbc_regs_properties #(.RSTOUT_CYC(RSTOUT_CYC)) u_props (
  .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), .restart(restart),
  .failsafe_entry(failsafe_entry), .hw_ch3_mode_wr(hw_ch3_mode_wr), .hw_ch3_mode(hw_ch3_mode),
  .supply_config_pin(supply_config_pin), .battery_sense_low(battery_sense_low),
  .adc_battery_sel_q(adc_battery_sel_q), .boost_lowbatt_cutoff_q(boost_lowbatt_cutoff_q),
  .boost_off_q(boost_off_q), .boost_level_q(boost_level_q),
  .aux_supply_level_sel_q(aux_supply_level_sel_q), .ch3_mode_q(ch3_mode_q),
  .wake_period_sel_q(wake_period_sel_q), .wake_interval_ms_q(wake_interval_ms_q),
  .reset_out_n_q(reset_out_n_q));

// ---- dv/spi_host_model.sv ----
// Purpose: Host serial master issuing 16-bit frames
// Assumes: Serial clock period 8 clk, idle low
// Notes:   Data bit i changes while clock low, reply sampled on rise
module spi_host_model (
  // System
  input  wire  clk,
  // Serial pins
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input  wire  spi_miso_q
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Frame bit 0 first: address, access bit, data byte
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    spi_cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < 16; i++)
    begin
      spi_mosi = tx[i];
      tick(4);
      spi_sck = 1'b1;
      rx[i] = spi_miso_q;
      tick(4);
      spi_sck = 1'b0;
    end
    tick(4);
    spi_cs_n = 1'b1;
    // Released data line shows inverse, gap keeps 8 clk
    spi_mosi = ~spi_mosi;
    tick(8);
  endtask
endmodule // spi_host_model

// ---- dv/sbc_control_status_regs_test.sv ----
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives the serial pins
// Notes:   Model array m holds expected register bytes
module test_sbc_control_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 8;
  logic        clk, rst_b, normal_mode, soft_reset, restart, failsafe_entry, hw_ch3_mode_wr;
  logic        supply_config_pin, battery_sense_low;
  logic [1:0]  hw_ch3_mode;
  logic [7:0]  status_event;
  logic [15:0] lf = 16'h328d;
  logic [6:0]  adr[6] = '{7'h0b, 7'h0c, 7'h0e, 7'h1e, 7'h40, 7'h20};
  wire         spi_sck, spi_cs_n, spi_mosi, miso, oe_n, adc, cut, boff, f0, f3, rst_o;
  wire  [1:0]  boost, aux, mode;
  wire  [2:0]  per;
  wire  [10:0] ivl;
  wire         miso_line = oe_n ? 1'bz : miso;
  int          n_errors = 0, tests_run = 0, m[128];
  int          ms[8] = '{10, 20, 50, 100, 200, 1000, 2000, 0};

  sbc_control_status_regs #(.RSTOUT_CYC(RC)) DUT (
    .clk(clk), .rst_b(rst_b), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_q(miso), .spi_miso_oe_n_q(oe_n), .normal_mode(normal_mode),
    .soft_reset(soft_reset), .restart(restart), .failsafe_entry(failsafe_entry),
    .hw_ch3_mode_wr(hw_ch3_mode_wr), .hw_ch3_mode(hw_ch3_mode), .status_event(status_event),
    .supply_config_pin(supply_config_pin), .battery_sense_low(battery_sense_low),
    .adc_battery_sel_q(adc), .boost_lowbatt_cutoff_q(cut), .boost_off_q(boff),
    .boost_level_q(boost), .aux_supply_level_sel_q(aux), .ch0_fast_q(f0), .ch3_fast_q(f3),
    .ch3_mode_q(mode), .wake_period_sel_q(per), .wake_interval_ms_q(ivl), .reset_out_n_q(rst_o));
  spi_host_model host (.clk(clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_q(miso_line));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #2_000_000;
    n_errors++;
    close_out();
  end

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction

  function automatic int msk(input logic [6:0] a);
    case (a)
      7'h0b: return 8'h1b;
      7'h0c: return 8'h07;
      7'h0e: return 8'hef;
      7'h1e: return 8'hff;
      default: return 0;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic fire(input int k);
    {soft_reset, restart, failsafe_entry, hw_ch3_mode_wr} = 4'(k);
    tick(1);
    {soft_reset, restart, failsafe_entry, hw_ch3_mode_wr} = 4'h0;
  endtask

  task automatic outs();
    chk(16'({adc, cut, boost, aux}), 16'({m[14][7], m[14][5], m[14][3:0]}));
    chk(16'({f0, f3, mode, per}), 16'({m[11][4:3], m[11][1:0], m[12][2:0]}));
    chk(ivl, 16'(ms[m[12][2:0]]));
  endtask

  // One frame, reply checked against the model, then model updated
  task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] d);
    logic [15:0] rx;
    logic        hid;
    hid = a == 7'h1e && !normal_mode;
    host.xfer({d, w, a}, rx);
    chk(rx, {hid ? 8'h0 : m[a][7:0], 7'h0, m[64] != 0});
    if (w && !hid)
      m[a] = a == 7'h40 ? 0 : d & msk(a);
    if (!supply_config_pin)
      m[14] = m[14] & 8'hfc | 1;
    outs();
    chk(oe_n, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {rst_b, normal_mode, soft_reset, restart, failsafe_entry, hw_ch3_mode_wr} = 6'h0;
    {hw_ch3_mode, status_event, battery_sense_low} = 11'h0;
    supply_config_pin = 1'b1;
    m = '{default: 0};
    m[14] = 1;
    repeat (8) @(posedge clk);
    #2;
    rst_b = 1'b1;
    normal_mode = 1'b1;
    tick(1);
    chk(rst_o, 1'b0);
    tick(RC + 1);
    chk(rst_o, 1'b1);
    foreach (adr[i]) acc(adr[i], 1'b0, rnd());
    repeat (6) foreach (adr[i]) acc(adr[i], 1'b1, rnd());
    for (int c = 0; c < 8; c++) acc(7'h0c, 1'b1, rnd() & 8'hf8 | 8'(c));
    status_event = 8'h81;
    tick(1);
    status_event = 8'h00;
    m[64] = 8'h81;
    acc(7'h40, 1'b0, rnd());
    acc(7'h40, 1'b1, 8'h5a);
    acc(7'h40, 1'b0, rnd());
    normal_mode = 1'b0;
    acc(7'h1e, 1'b1, 8'ha5);
    normal_mode = 1'b1;
    acc(7'h1e, 1'b0, 8'h00);
    acc(7'h0e, 1'b1, 8'haf);
    acc(7'h0b, 1'b1, 8'h1a);
    fire(8);
    m[11] = 0;
    m[12] = 0;
    m[14] &= 3;
    tick(1);
    chk(rst_o, 1'b0);
    tick(RC - 1);
    chk(rst_o, 1'b0);
    tick(1);
    chk(rst_o, 1'b1);
    foreach (adr[i]) acc(adr[i], 1'b0, 8'h00);
    acc(7'h0e, 1'b1, 8'h40);
    fire(8);
    m[14] &= 3;
    tick(2);
    chk(rst_o, 1'b1);
    foreach (adr[i]) acc(adr[i], 1'b1, rnd());
    fire(4);
    m[12] = 0;
    m[14] &= 8'h5f;
    tick(1);
    outs();
    fire(2);
    m[11] = m[11] & 8'hfc | 1;
    outs();
    hw_ch3_mode = 2'h2;
    fire(1);
    m[11] = m[11] & 8'hfc | 2;
    acc(7'h1e, 1'b0, 8'h00);
    acc(7'h0e, 1'b1, 8'h02);
    supply_config_pin = 1'b0;
    m[14] = m[14] & 8'hfc | 1;
    tick(6);
    acc(7'h0e, 1'b1, 8'h03);
    acc(7'h0e, 1'b0, 8'h00);
    supply_config_pin = 1'b1;
    acc(7'h0e, 1'b1, 8'h20);
    battery_sense_low = 1'b1;
    tick(6);
    chk(boff, 1'b1);
    acc(7'h0e, 1'b1, 8'h00);
    chk(boff, 1'b0);
    close_out();
  end
endmodule // test_sbc_control_status_regs
